/* File: pkg/tmc_consts.vh */
/*
 constants for the 16-bit match-clear timer / event counter: register
 addresses, field positions, reset values and count-clock choices.
 assumes it is included by bare name from design files of the block.
*/
// How it works
// - direction bit 0 output, 1 input
// - reset loads pin direction with all ones
// - direction register takes bit and byte writes
// - mode 11 starts counting on count clock
// - match with compare A raises interrupt, clears in mode 11
// - match interval in mode 11 is compare A plus one
// - compare B match always raises its request
// - mode 00 stops and clears the counter
// - output control 03 toggles pin per compare A match
// - clock select 11 counts event input edges
// - no event counting in mode 10
// - first event match after compare plus two
// - edge accepted after two equal samples
// - edge select 00 fall, 01 rise, 11 both
// - count read never disturbs counting
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

`define TMC_ADDR_PIN_DIR     16'hff20
`define TMC_ADDR_MODE_CTRL   16'hff60
`define TMC_ADDR_CAPCMP_CTRL 16'hff61
`define TMC_ADDR_OUT_CTRL    16'hff62
`define TMC_ADDR_PRESCALE    16'hff63
`define TMC_ADDR_COUNT       16'hff64
`define TMC_ADDR_CMP_A       16'hff66
`define TMC_ADDR_CMP_B       16'hff68

`define TMC_PIN_DIR_RST      8'hff
`define TMC_PIN_DIR_FIXED    8'hfc
`define TMC_REG8_RST         8'h00
`define TMC_REG16_RST        16'h0000

`define TMC_MODE_HI          3
`define TMC_MODE_LO          2
`define TMC_MODE_STOP        2'b00
`define TMC_MODE_FREE        2'b01
`define TMC_MODE_EDGE_CLR    2'b10
`define TMC_MODE_MATCH_CLR   2'b11

`define TMC_OUT_ENABLE       0
`define TMC_OUT_TOGGLE_A     1
`define TMC_OUT_FORCE_LOW    2
`define TMC_OUT_FORCE_HIGH   3

`define TMC_CSEL_HI          1
`define TMC_CSEL_LO          0
`define TMC_ESEL_HI          5
`define TMC_ESEL_LO          4
`define TMC_CSEL_DIV1        2'b00
`define TMC_CSEL_DIV4        2'b01
`define TMC_CSEL_DIV256      2'b10
`define TMC_CSEL_EVENT       2'b11
`define TMC_DIV4_MASK        8'h03
`define TMC_DIV256_MASK      8'hff

`define TMC_EDGE_FALL        2'b00
`define TMC_EDGE_RISE        2'b01
`define TMC_EDGE_BOTH        2'b11

`endif

/* File: design/tmc_prescaler.v */
/*
 internal count-clock divider: one-cycle tick at the selected rate.
 assumes i_run is low while the timer is stopped so phase restarts.
*/
`timescale 1ns/1ps
`include "tmc_consts.vh"

module tmc_prescaler (
   // clock and reset
   input  wire       i_clk,
   input  wire       i_sys_rst,
   // control
   input  wire       i_run,
   input  wire [1:0] i_sel,
   // tick out
   output reg        o_tick
);

   reg  [7:0] div_q;
   reg        tick_d;

   always @* begin
      case (i_sel)
         `TMC_CSEL_DIV1:   tick_d = i_run;
         `TMC_CSEL_DIV4:   tick_d = i_run & ((div_q & `TMC_DIV4_MASK) == `TMC_DIV4_MASK);
         `TMC_CSEL_DIV256: tick_d = i_run & (div_q == `TMC_DIV256_MASK);
         default:          tick_d = 1'b0;
      endcase
   end

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_q  <= 8'h00;
         o_tick <= 1'b0;
      end else begin
         div_q  <= i_run ? div_q + 8'h01 : 8'h00;
         o_tick <= tick_d;
      end
   end

endmodule // tmc_prescaler

/* File: design/tmc_edge_filter.v */
/*
 event input pin conditioning: synchroniser, two-sample noise filter
 and valid-edge selection; emits a one-cycle pulse per accepted edge.
 assumes the pin is asynchronous to i_clk.
*/
`timescale 1ns/1ps
`include "tmc_consts.vh"

module tmc_edge_filter (
   // clock and reset
   input  wire       i_clk,
   input  wire       i_sys_rst,
   // pin and edge choice
   input  wire       i_pin,
   input  wire [1:0] i_edge_sel,
   // accepted edge
   output reg        o_edge
);

   reg  sync1_q;
   reg  sync2_q;
   reg  samp_q;
   reg  level_q;
   wire change;

   function edge_ok;
      input [1:0] sel;
      input       new_level;
      begin
         case (sel)
            `TMC_EDGE_FALL: edge_ok = ~new_level;
            `TMC_EDGE_RISE: edge_ok = new_level;
            `TMC_EDGE_BOTH: edge_ok = 1'b1;
            default:        edge_ok = 1'b0;
         endcase
      end
   endfunction

   assign change = (sync2_q == samp_q) && (sync2_q != level_q);

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         samp_q  <= 1'b0;
         level_q <= 1'b0;
         o_edge  <= 1'b0;
      end else begin
         sync1_q <= i_pin;
         sync2_q <= sync1_q;
         samp_q  <= sync2_q;
         if (change) begin
            level_q <= sync2_q;
         end
         o_edge  <= change & edge_ok(i_edge_sel, sync2_q);
      end
   end

endmodule // tmc_edge_filter

/* File: design/tmc_timer16.v */
/*
 16-bit timer / event counter with compare-A clear, compare-B match,
 square-wave output and the port-0 pin direction register.
 assumes a single-master register port: one access per cycle, 16-bit
 data for 16-bit registers, low byte for 8-bit ones; bit writes act on
 8-bit registers only. interrupt masking lives in the interrupt unit.
*/
`timescale 1ns/1ps
`include "tmc_consts.vh"

module tmc_timer16 (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_sys_rst,
   // register port
   input  wire [15:0] i_sfr_addr,
   input  wire        i_sfr_wr,
   input  wire [15:0] i_sfr_wdata,
   input  wire        i_sfr_bit_wr,
   input  wire [2:0]  i_sfr_bit_sel,
   input  wire        i_sfr_bit_val,
   input  wire        i_sfr_rd,
   output reg  [15:0] o_sfr_rdata,
   // pins
   input  wire        i_event_input_pin,
   output reg         o_timer_output_pin,
   output reg  [1:0]  o_pin_oe,
   // interrupt requests
   output reg         o_compare_a_interrupt,
   output reg         o_compare_b_interrupt
);

   // registers
   reg  [7:0]  port0_pin_direction_q;
   reg  [7:0]  timer_mode_control_q;
   reg  [7:0]  capture_compare_control_q;
   reg  [7:0]  timer_output_control_q;
   reg  [7:0]  prescaler_edge_select_q;
   reg  [15:0] compare_register_a_q;
   reg  [15:0] compare_register_b_q;
   reg  [15:0] count_value_q;
   reg         armed_q;

   reg  [7:0]  port0_pin_direction_d;
   reg  [7:0]  timer_mode_control_d;
   reg  [7:0]  capture_compare_control_d;
   reg  [7:0]  timer_output_control_d;
   reg  [7:0]  prescaler_edge_select_d;
   reg  [15:0] rdata_d;

   wire        hit_dir;
   wire        hit_mode;
   wire        hit_capcmp;
   wire        hit_out;
   wire        hit_pre;
   wire        hit_cmp_a;
   wire        hit_cmp_b;
   wire [1:0]  op_mode;
   wire [1:0]  clock_select;
   wire [1:0]  event_edge_sel;
   wire        running;
   wire        presc_tick;
   wire        event_edge;
   wire        count_tick;
   wire        match_a;
   wire        match_b;
   wire        out_enable;

   // byte or single-bit update of an 8-bit register
   function [7:0] sfr_merge;
      input [7:0] old;
      input       hit;
      input       wr;
      input [7:0] wd;
      input       bwr;
      input [2:0] bsel;
      input       bval;
      begin
         sfr_merge = old;
         if (hit && wr) begin
            sfr_merge = wd;
         end else if (hit && bwr) begin
            sfr_merge[bsel] = bval;
         end
      end
   endfunction

   assign hit_dir    = (i_sfr_addr == `TMC_ADDR_PIN_DIR);
   assign hit_mode   = (i_sfr_addr == `TMC_ADDR_MODE_CTRL);
   assign hit_capcmp = (i_sfr_addr == `TMC_ADDR_CAPCMP_CTRL);
   assign hit_out    = (i_sfr_addr == `TMC_ADDR_OUT_CTRL);
   assign hit_pre    = (i_sfr_addr == `TMC_ADDR_PRESCALE);
   assign hit_cmp_a  = (i_sfr_addr == `TMC_ADDR_CMP_A);
   assign hit_cmp_b  = (i_sfr_addr == `TMC_ADDR_CMP_B);

   assign op_mode        = timer_mode_control_q[`TMC_MODE_HI:`TMC_MODE_LO];
   assign clock_select   = prescaler_edge_select_q[`TMC_CSEL_HI:`TMC_CSEL_LO];
   assign event_edge_sel = prescaler_edge_select_q[`TMC_ESEL_HI:`TMC_ESEL_LO];
   assign out_enable     = timer_output_control_q[`TMC_OUT_ENABLE];
   assign running        = (op_mode != `TMC_MODE_STOP);

   always @* begin
      port0_pin_direction_d = sfr_merge(port0_pin_direction_q, hit_dir, i_sfr_wr,
                                        i_sfr_wdata[7:0], i_sfr_bit_wr,
                                        i_sfr_bit_sel, i_sfr_bit_val)
                              | `TMC_PIN_DIR_FIXED;
      timer_mode_control_d = sfr_merge(timer_mode_control_q, hit_mode, i_sfr_wr,
                                       i_sfr_wdata[7:0], i_sfr_bit_wr,
                                       i_sfr_bit_sel, i_sfr_bit_val);
      capture_compare_control_d = sfr_merge(capture_compare_control_q, hit_capcmp,
                                            i_sfr_wr, i_sfr_wdata[7:0], i_sfr_bit_wr,
                                            i_sfr_bit_sel, i_sfr_bit_val);
      timer_output_control_d = sfr_merge(timer_output_control_q, hit_out, i_sfr_wr,
                                         i_sfr_wdata[7:0], i_sfr_bit_wr,
                                         i_sfr_bit_sel, i_sfr_bit_val);
      prescaler_edge_select_d = sfr_merge(prescaler_edge_select_q, hit_pre, i_sfr_wr,
                                          i_sfr_wdata[7:0], i_sfr_bit_wr,
                                          i_sfr_bit_sel, i_sfr_bit_val);
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rdata_d = 16'h0000;
      if (hit_dir) begin
         rdata_d = {8'h00, port0_pin_direction_q};
      end else if (hit_mode) begin
         rdata_d = {8'h00, timer_mode_control_q};
      end else if (hit_capcmp) begin
         rdata_d = {8'h00, capture_compare_control_q};
      end else if (hit_out) begin
         rdata_d = {8'h00, timer_output_control_q};
      end else if (hit_pre) begin
         rdata_d = {8'h00, prescaler_edge_select_q};
      end else if (i_sfr_addr == `TMC_ADDR_COUNT) begin
         rdata_d = count_value_q;
      end else if (hit_cmp_a) begin
         rdata_d = compare_register_a_q;
      end else if (hit_cmp_b) begin
         rdata_d = compare_register_b_q;
      end
   end

   tmc_prescaler u_prescaler (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (running),
      .i_sel     (clock_select),
      .o_tick    (presc_tick)
   );

   tmc_edge_filter u_edge_filter (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_pin      (i_event_input_pin),
      .i_edge_sel (event_edge_sel),
      .o_edge     (event_edge)
   );

   // no event count in mode 10
   assign count_tick = running &
                       ((clock_select == `TMC_CSEL_EVENT) ?
                        (event_edge & (op_mode != `TMC_MODE_EDGE_CLR)) : presc_tick);

   assign match_a = count_tick & armed_q & (count_value_q == compare_register_a_q);
   assign match_b = count_tick & armed_q & (count_value_q == compare_register_b_q);

   // register file
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         port0_pin_direction_q     <= `TMC_PIN_DIR_RST;
         timer_mode_control_q      <= `TMC_REG8_RST;
         capture_compare_control_q <= `TMC_REG8_RST;
         timer_output_control_q    <= `TMC_REG8_RST;
         prescaler_edge_select_q   <= `TMC_REG8_RST;
         compare_register_a_q      <= `TMC_REG16_RST;
         compare_register_b_q      <= `TMC_REG16_RST;
         o_pin_oe                  <= 2'b00;
         o_sfr_rdata               <= 16'h0000;
      end else begin
         port0_pin_direction_q     <= port0_pin_direction_d;
         timer_mode_control_q      <= timer_mode_control_d;
         capture_compare_control_q <= capture_compare_control_d;
         timer_output_control_q    <= timer_output_control_d;
         prescaler_edge_select_q   <= prescaler_edge_select_d;
         if (hit_cmp_a && i_sfr_wr) begin
            compare_register_a_q <= i_sfr_wdata;
         end
         if (hit_cmp_b && i_sfr_wr) begin
            compare_register_b_q <= i_sfr_wdata;
         end
         o_pin_oe <= ~port0_pin_direction_d[1:0];
         if (i_sfr_rd) begin
            o_sfr_rdata <= rdata_d;
         end
      end
   end

   // counter
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_value_q <= 16'h0000;
         armed_q       <= 1'b0;
      end else if (!running) begin
         count_value_q <= 16'h0000;
         armed_q       <= 1'b0;
      end else if (count_tick) begin
         if (!armed_q) begin
            armed_q <= 1'b1;
         end else if (match_a && (op_mode == `TMC_MODE_MATCH_CLR)) begin
            count_value_q <= 16'h0000;
         end else begin
            count_value_q <= count_value_q + 16'h0001;
         end
      end
   end

   // interrupts and timer output
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_compare_a_interrupt <= 1'b0;
         o_compare_b_interrupt <= 1'b0;
         o_timer_output_pin    <= 1'b0;
      end else begin
         o_compare_a_interrupt <= match_a;
         o_compare_b_interrupt <= match_b;
         if (!out_enable) begin
            o_timer_output_pin <= 1'b0;
         end else if (hit_out && i_sfr_wr &&
                      i_sfr_wdata[`TMC_OUT_FORCE_HIGH]) begin
            o_timer_output_pin <= 1'b1;
         end else if (hit_out && i_sfr_wr &&
                      i_sfr_wdata[`TMC_OUT_FORCE_LOW]) begin
            o_timer_output_pin <= 1'b0;
         end else if (match_a && timer_output_control_q[`TMC_OUT_TOGGLE_A]) begin
            o_timer_output_pin <= ~o_timer_output_pin;
         end
      end
   end

endmodule // tmc_timer16

/* File: tb/tmc_timer16_properties.sv */
/*
 port assertions for tmc_timer16.
 assumes it is bound to the timer top and sees its ports only.
*/
`timescale 1ns/1ps
module tmc_timer16_props (
   // clock and reset
   input wire        i_clk,
   input wire        i_sys_rst,
   // register port
   input wire [15:0] i_sfr_addr,
   input wire        i_sfr_wr,
   input wire [15:0] i_sfr_wdata,
   input wire        i_sfr_bit_wr,
   input wire [2:0]  i_sfr_bit_sel,
   input wire        i_sfr_bit_val,
   input wire        i_sfr_rd,
   input wire [15:0] o_sfr_rdata,
   // pins and requests
   input wire        o_timer_output_pin,
   input wire [1:0]  o_pin_oe,
   input wire        o_compare_a_interrupt,
   input wire        o_compare_b_interrupt
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_oe_rst; $past(i_sys_rst) |-> o_pin_oe == 2'h0; endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("pin drivers on after reset");

   property p_dir_byte;
      i_sfr_wr && i_sfr_addr == 16'hff20 |=> o_pin_oe == ~$past(i_sfr_wdata[1:0]);
   endproperty
   a_dir_byte: assert property (p_dir_byte) else $error("byte write to direction lost");

   property p_dir_bit;
      i_sfr_bit_wr && !i_sfr_wr && i_sfr_addr == 16'hff20 && i_sfr_bit_sel == 3'h1
      |=> o_pin_oe[1] == !$past(i_sfr_bit_val);
   endproperty
   a_dir_bit: assert property (p_dir_bit) else $error("bit write to direction lost");

   property p_dir_rd;
      i_sfr_rd && i_sfr_addr == 16'hff20 |=> o_sfr_rdata == {8'hff, 6'h3f, ~$past(o_pin_oe)} - 16'hff00;
   endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("direction readback wrong");

   property p_a_pulse; o_compare_a_interrupt |=> !o_compare_a_interrupt; endproperty
   a_a_pulse: assert property (p_a_pulse) else $error("compare a request too long");

   property p_b_pulse; o_compare_b_interrupt |=> !o_compare_b_interrupt; endproperty
   a_b_pulse: assert property (p_b_pulse) else $error("compare b request too long");

   property p_stop;
      i_sfr_wr && i_sfr_addr == 16'hff60 && i_sfr_wdata[3:2] == 2'h0
      |-> ##3 (!o_compare_a_interrupt && !o_compare_b_interrupt)[*5];
   endproperty
   a_stop: assert property (p_stop) else $error("match request while stopped");

   property p_out;
      $changed(o_timer_output_pin) |-> o_compare_a_interrupt || $past(o_compare_a_interrupt)
         || $past(i_sfr_wr) || $past(i_sfr_wr, 2) || $past(i_sfr_bit_wr) || $past(i_sfr_bit_wr, 2);
   endproperty
   a_out: assert property (p_out) else $error("output pin moved without cause");

   property p_rd_hold; !$past(i_sfr_rd) |-> $stable(o_sfr_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule // tmc_timer16_props

bind tmc_timer16 tmc_timer16_props tmc_timer16_props_i (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
   .i_sfr_wdata(i_sfr_wdata), .i_sfr_bit_wr(i_sfr_bit_wr), .i_sfr_bit_sel(i_sfr_bit_sel),
   .i_sfr_bit_val(i_sfr_bit_val), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
   .o_timer_output_pin(o_timer_output_pin), .o_pin_oe(o_pin_oe),
   .o_compare_a_interrupt(o_compare_a_interrupt), .o_compare_b_interrupt(o_compare_b_interrupt));

/* File: tb/tmc_event_src.sv */
/*
 external event source driving the timer event pin.
 assumes tasks are called from the bench on falling clock edges.
*/
`timescale 1ns/1ps
module tmc_event_src (
   // clock
   input wire i_clk,
   // pin
   output reg o_pin
);
   initial o_pin = 1'b0;
   // level held hold plus one clocks per toggle
   task toggle(input integer n, input integer hold);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            @(negedge i_clk);
            o_pin = ~o_pin;
            repeat (hold) @(negedge i_clk);
         end
      end
   endtask
   // one-clock noise spike, too short to count
   task glitch;
      begin
         @(negedge i_clk);
         o_pin = ~o_pin;
         @(negedge i_clk);
         o_pin = ~o_pin;
      end
   endtask
endmodule // tmc_event_src

/* File: tb/tmc_timer16_tb.sv */
/*
 self-checking bench for tmc_timer16 through its register port.
 assumes tmc_event_src drives the event pin.
*/
`timescale 1ns/1ps
module tmc_timer16_tb;
   reg         i_clk = 1'b0;
   reg         i_sys_rst = 1'b1;
   reg  [15:0] addr = 16'h0000;
   reg  [15:0] wdata = 16'h0000;
   reg         wr = 1'b0;
   reg         bwr = 1'b0;
   reg  [2:0]  bsel = 3'h0;
   reg         bval = 1'b0;
   reg         rd = 1'b0;
   wire [15:0] rdata;
   wire        pin;
   wire        out_pin;
   wire [1:0]  oe;
   wire        irq_a;
   wire        irq_b;
   integer     num_errors = 0;
   integer     cmp_count = 0;
   integer     na = 0, nb = 0, ntg = 0, cyc = 0, gap = 0, last = 0;
   integer     e, k, na0, nb0, t0;
   reg  [15:0] d;
   reg  [1:0]  es;

   always #12.5 i_clk = ~i_clk;

   tmc_timer16 tmc_timer16_i (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
      .i_sfr_wdata(wdata), .i_sfr_bit_wr(bwr), .i_sfr_bit_sel(bsel), .i_sfr_bit_val(bval),
      .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_event_input_pin(pin),
      .o_timer_output_pin(out_pin), .o_pin_oe(oe), .o_compare_a_interrupt(irq_a),
      .o_compare_b_interrupt(irq_b));
   tmc_event_src tmc_event_src_i (.i_clk(i_clk), .o_pin(pin));

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (irq_a === 1'b1) begin
         na <= na + 1;
         gap <= cyc - last;
         last <= cyc;
      end
      if (irq_b === 1'b1) nb <= nb + 1;
   end
   always @(out_pin) ntg = ntg + 1;

   task close_out;
      begin
         $display("compares %0d mismatches %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wreg(input [15:0] a, input [15:0] v);
      begin
         @(negedge i_clk);
         addr = a;
         wdata = v;
         wr = 1'b1;
         @(negedge i_clk);
         wr = 1'b0;
      end
   endtask
   task wbit(input [2:0] s, input v);
      begin
         @(negedge i_clk);
         addr = 16'hff20;
         bsel = s;
         bval = v;
         bwr = 1'b1;
         @(negedge i_clk);
         bwr = 1'b0;
      end
   endtask
   task rreg(input [15:0] a, output [15:0] v);
      begin
         @(negedge i_clk);
         addr = a;
         rd = 1'b1;
         @(negedge i_clk);
         rd = 1'b0;
         v = rdata;
      end
   endtask
   task stop;
      begin
         wreg(16'hff60, 16'h0000);
         repeat (8) @(negedge i_clk);
      end
   endtask
   task wait_a(input integer n);
      integer w;
      begin
         w = 0;
         while (na < n && w < 3000) begin
            @(negedge i_clk);
            w = w + 1;
         end
         if (w == 3000) begin
            num_errors = num_errors + 1;
            close_out;
         end
      end
   endtask

   initial begin
      repeat (5) @(negedge i_clk);
      i_sys_rst = 1'b0;
      rreg(16'hff20, d);
      check(d, 16'h00ff);
      check({14'h0, oe}, 16'h0000);
      wreg(16'hff20, 16'h0000);
      rreg(16'hff20, d);
      check(d, 16'h00fc);
      check({14'h0, oe}, 16'h0003);
      wbit(3'h0, 1'b1);
      wbit(3'h1, 1'b1);
      wbit(3'h1, 1'b0);
      rreg(16'hff20, d);
      check(d, 16'h00fd);
      check({14'h0, oe}, 16'h0002);
      rreg(16'hff70, d);
      check(d, 16'h0000);
      wreg(16'hff64, 16'h1234);
      rreg(16'hff64, d);
      check(d, 16'h0000);
      wreg(16'hff63, 16'h0000);
      wreg(16'hff61, 16'h0005);
      rreg(16'hff61, d);
      check(d, 16'h0005);
      wreg(16'hff66, 16'h0003);
      wreg(16'hff68, 16'h0001);
      wreg(16'hff62, 16'h0003);
      na0 = na;
      nb0 = nb;
      t0 = ntg;
      wreg(16'hff60, 16'h000c);
      wait_a(na0 + 3);
      check(16'(gap), 16'h0004);
      check(16'(ntg - t0), 16'h0003);
      check(16'(nb - nb0), 16'h0003);
      stop;
      wreg(16'hff63, 16'h0001);
      wreg(16'hff60, 16'h000c);
      wait_a(na + 2);
      check(16'(gap), 16'h0010);
      stop;
      wreg(16'hff63, 16'h0002);
      wreg(16'hff66, 16'h0001);
      wreg(16'hff60, 16'h000c);
      wait_a(na + 2);
      check(16'(gap), 16'h0200);
      stop;
      wreg(16'hff63, 16'h0000);
      wreg(16'hff60, 16'h0004);
      // the first count tick only arms the counter, so let it settle
      repeat (4) @(negedge i_clk);
      @(negedge i_clk);
      addr = 16'hff64;
      rd = 1'b1;
      @(negedge i_clk);
      d = rdata;
      @(negedge i_clk);
      rd = 1'b0;
      check(rdata - d, 16'h0001);
      stop;
      rreg(16'hff64, d);
      check(d, 16'h0000);
      wreg(16'hff62, 16'h000b);
      check({15'h0, out_pin}, 16'h0001);
      wreg(16'hff62, 16'h0007);
      check({15'h0, out_pin}, 16'h0000);
      wreg(16'hff62, 16'h0003);
      wreg(16'hff20, 16'h00ff);
      wreg(16'hff66, 16'h0002);
      for (e = 0; e < 3; e = e + 1) begin
         es = (e == 0) ? 2'h0 : (e == 1) ? 2'h1 : 2'h3;
         k = (e == 2) ? 1 : 2;
         stop;
         wreg(16'hff63, {10'h0, es, 4'h3});
         wreg(16'hff60, 16'h000c);
         na0 = na;
         tmc_event_src_i.toggle(3 * k, 3);
         tmc_event_src_i.glitch;
         repeat (6) @(negedge i_clk);
         check(16'(na - na0), 16'h0000);
         tmc_event_src_i.toggle(k, 3);
         repeat (6) @(negedge i_clk);
         check(16'(na - na0), 16'h0001);
         tmc_event_src_i.toggle(3 * k, 3);
         repeat (6) @(negedge i_clk);
         check(16'(na - na0), 16'h0002);
      end
      stop;
      wreg(16'hff63, 16'h0033);
      wreg(16'hff60, 16'h0008);
      tmc_event_src_i.toggle(4, 3);
      repeat (6) @(negedge i_clk);
      rreg(16'hff64, d);
      check(d, 16'h0000);
      stop;
      close_out;
   end
endmodule // tmc_timer16_tb
